// [hdl/clock_switch_pkg.sv]
// Function
// - delay frequency change until stopped oscillator starts
// - status shows HF and LF ready, each only while that oscillator is enabled and started
// - start-up delay first, before any handover
// - outgoing falling edge, hold low, incoming rising
// - update status bits, then finish switch
// - same-oscillator frequency change has no start-up delay
// - source select drives core and peripheral clock
// - source 00 uses configuration clock select
// - source 01 uses secondary oscillator
// - source 1x uses frequency-selected internal output
// - reset clears source select to zero
// - switch delays: LF one each, HF 2us, external two
// - stop LF after LF-to-HF unless watchdog
// - keep LF running while peripherals request it
// - frequency codes map to HF postscaler or LF
// - HF stable flag set once HF drives clock
`default_nettype none

package clock_switch_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned HF_STARTUP_NS     = 2000;
  // least time: round up to whole cycles
  localparam int unsigned HF_STARTUP_CYCLES =
    (HF_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LF_SWITCH_EDGES   = 1;
  localparam int unsigned EXT_SWITCH_EDGES  = 2;
  localparam int unsigned SYNC_EDGES        = 2;

  // ==========================================================
  // register map
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;

  localparam int unsigned FREQ_LSB         = 3;
  localparam int unsigned SRC_LSB          = 0;
  localparam int unsigned STAT_HF_READY    = 4;
  localparam int unsigned STAT_LF_READY    = 1;
  localparam int unsigned STAT_HF_STABLE   = 0;
  localparam int unsigned STAT_SWITCH_BUSY = 8;

  localparam logic [3:0] FREQ_RESET = 4'h7;
  localparam logic [1:0] SRC_RESET  = 2'h0;

  // source select and configuration encodings
  localparam logic [1:0] SRC_SEL_CONFIG    = 2'h0;
  localparam logic [1:0] SRC_SEL_SECONDARY = 2'h1;
  localparam logic [1:0] CFG_INTERNAL      = 2'h0;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_HF,
    SRC_LF,
    SRC_SEC,
    SRC_EXT
  } src_t;

  // a clock choice: oscillator plus postscaler exponent
  typedef struct packed {
    src_t       src;
    logic [3:0] div_exp;
  } clk_sel_t;

  localparam clk_sel_t SEL_NONE = '{src: SRC_NONE, div_exp: 4'h0};

endpackage

`default_nettype wire

// [hdl/pin_sync.sv]
`default_nettype none

module pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // meta is read only by the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

`default_nettype wire

// [hdl/system_clock_switch.sv]
`default_nettype none

module system_clock_switch (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // oscillator and clock pins
  input  wire logic        hf_internal_osc,
  input  wire logic        lf_internal_osc,
  input  wire logic        secondary_osc,
  input  wire logic        ext_clock_in,
  // configuration and requests
  input  wire logic [1:0]  cfg_clock_select,
  input  wire logic        watchdog_enable,
  input  wire logic        periph_lf_request,
  // oscillator enables and system clock
  output var  logic        hf_osc_enable,
  output var  logic        lf_osc_enable,
  output var  logic        sys_clk,
  output var  logic        switch_busy
);

  // ==========================================================
  // types and local constants
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_SYNC,
    ST_WAIT_FALL,
    ST_HOLD_LOW,
    ST_UPDATE
  } switch_state_t;

  localparam int unsigned HF_CNT_W = $clog2(clock_switch_pkg::HF_STARTUP_CYCLES + 1);
  localparam logic [HF_CNT_W-1:0] HF_CNT_END =
    HF_CNT_W'(clock_switch_pkg::HF_STARTUP_CYCLES);
  localparam logic [1:0] LF_EDGES   = 2'(clock_switch_pkg::LF_SWITCH_EDGES);
  localparam logic [1:0] EXT_EDGES  = 2'(clock_switch_pkg::EXT_SWITCH_EDGES);
  localparam logic [1:0] SYNC_EDGES = 2'(clock_switch_pkg::SYNC_EDGES);

  // ==========================================================
  // functions

  // frequency code and source select to a clock choice
  function automatic clock_switch_pkg::clk_sel_t decode_sel(
    input logic [3:0] freq,
    input logic [1:0] src_sel,
    input logic [1:0] cfg
  );
    clock_switch_pkg::clk_sel_t s;
    s = clock_switch_pkg::SEL_NONE;
    if (!src_sel[1] && src_sel == clock_switch_pkg::SRC_SEL_SECONDARY) begin
      s.src = clock_switch_pkg::SRC_SEC;
    end else if (!src_sel[1] && cfg != clock_switch_pkg::CFG_INTERNAL) begin
      s.src = clock_switch_pkg::SRC_EXT;
    end else if (freq[3:1] == 3'h0) begin
      s.src = clock_switch_pkg::SRC_LF;
    end else begin
      s.src = clock_switch_pkg::SRC_HF;
      case (freq)
        4'hf:    s.div_exp = 4'h0;
        4'he:    s.div_exp = 4'h1;
        4'hd:    s.div_exp = 4'h2;
        4'hc:    s.div_exp = 4'h3;
        4'hb:    s.div_exp = 4'h4;
        4'ha:    s.div_exp = 4'h5;
        4'h9:    s.div_exp = 4'h6;
        4'h8:    s.div_exp = 4'h7;
        4'h7:    s.div_exp = 4'h5;
        4'h6:    s.div_exp = 4'h6;
        4'h5:    s.div_exp = 4'h7;
        4'h4:    s.div_exp = 4'h8;
        default: s.div_exp = 4'h9;
      endcase
    end
    return s;
  endfunction

  // present level of a clock choice
  function automatic logic clock_level(
    input clock_switch_pkg::clk_sel_t s,
    input logic [8:0]                 div,
    input logic                       hf,
    input logic                       lf,
    input logic                       sec,
    input logic                       ext
  );
    logic lvl;
    lvl = 1'b0;
    case (s.src)
      clock_switch_pkg::SRC_HF:  lvl = (s.div_exp == 4'h0) ? hf : div[s.div_exp - 4'h1];
      clock_switch_pkg::SRC_LF:  lvl = lf;
      clock_switch_pkg::SRC_SEC: lvl = sec;
      clock_switch_pkg::SRC_EXT: lvl = ext;
      default:                   lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  // ==========================================================
  // pin synchronisers
  logic [8:0] pins_sync;
  logic       pins_valid;
  logic       hf_lvl;
  logic       lf_lvl;
  logic       sec_lvl;
  logic       ext_lvl;
  logic [1:0] cfg_sync;
  logic       wdt_sync;
  logic       periph_lf_sync;

  pin_sync #(
    .WIDTH (9)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({1'b1, periph_lf_request, watchdog_enable, cfg_clock_select,
                ext_clock_in, secondary_osc, lf_internal_osc, hf_internal_osc}),
    .sync_out (pins_sync)
  );

  assign hf_lvl         = pins_sync[0];
  assign lf_lvl         = pins_sync[1];
  assign sec_lvl        = pins_sync[2];
  assign ext_lvl        = pins_sync[3];
  assign cfg_sync       = pins_sync[5:4];
  assign wdt_sync       = pins_sync[6];
  assign periph_lf_sync = pins_sync[7];
  // constant one through the same stages: synced pins hold real values only once it is up
  assign pins_valid     = pins_sync[8];

  // ==========================================================
  // state
  logic [3:0]                 int_osc_freq_select;
  logic [1:0]                 sys_clock_source_select;
  clock_switch_pkg::clk_sel_t active_sel;
  clock_switch_pkg::clk_sel_t target_sel;
  clock_switch_pkg::clk_sel_t wanted_sel;
  switch_state_t              state;
  logic [8:0]                 div_cnt;
  logic                       hf_prev;
  logic                       lf_prev;
  logic                       cur_prev;
  logic                       new_prev;
  logic                       cur_lvl;
  logic                       new_lvl;
  logic                       new_rise;
  logic                       cur_rise;
  logic                       cur_fall;
  logic [1:0]                 new_edges;
  logic                       old_seen;
  logic [HF_CNT_W-1:0]        hf_start_cnt;
  logic                       hf_ready;
  logic                       lf_ready;
  logic                       hf_osc_stable_flag;
  logic                       start_done;

  assign wanted_sel = decode_sel(int_osc_freq_select, sys_clock_source_select, cfg_sync);
  assign cur_lvl    = clock_level(active_sel, div_cnt, hf_lvl, lf_lvl, sec_lvl, ext_lvl);
  assign new_lvl    = clock_level(target_sel, div_cnt, hf_lvl, lf_lvl, sec_lvl, ext_lvl);
  assign new_rise   = new_lvl & ~new_prev;
  assign cur_rise   = cur_lvl & ~cur_prev;
  assign cur_fall   = ~cur_lvl & cur_prev;

  // ==========================================================
  // hf postscaler and edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt  <= 9'h000;
      hf_prev  <= 1'b0;
      lf_prev  <= 1'b0;
      cur_prev <= 1'b0;
      new_prev <= 1'b0;
    end else begin
      hf_prev  <= hf_lvl;
      lf_prev  <= lf_lvl;
      cur_prev <= cur_lvl;
      new_prev <= new_lvl;
      // one counter feeds every postscaled tap, so taps stay phase aligned
      if (hf_lvl && !hf_prev) begin
        div_cnt <= div_cnt + 9'h001;
      end
    end
  end

  // ==========================================================
  // oscillator enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hf_osc_enable <= 1'b0;
      lf_osc_enable <= 1'b0;
    end else begin
      hf_osc_enable <= (active_sel.src == clock_switch_pkg::SRC_HF) ||
                       (state != ST_IDLE && target_sel.src == clock_switch_pkg::SRC_HF) ||
                       (pins_valid && wanted_sel.src == clock_switch_pkg::SRC_HF);
      // dropping lf from the active choice stops it unless someone else needs it
      lf_osc_enable <= (active_sel.src == clock_switch_pkg::SRC_LF) ||
                       (state != ST_IDLE && target_sel.src == clock_switch_pkg::SRC_LF) ||
                       (pins_valid && wanted_sel.src == clock_switch_pkg::SRC_LF) ||
                       wdt_sync || periph_lf_sync;
    end
  end

  // ==========================================================
  // oscillator ready tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hf_start_cnt <= '0;
      hf_ready     <= 1'b0;
    end else if (!hf_osc_enable) begin
      hf_start_cnt <= '0;
      hf_ready     <= 1'b0;
    end else if (hf_start_cnt != HF_CNT_END) begin
      hf_start_cnt <= hf_start_cnt + HF_CNT_W'(1);
    end else begin
      hf_ready <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lf_ready <= 1'b0;
    end else if (!lf_osc_enable) begin
      lf_ready <= 1'b0;
    end else if (lf_lvl && !lf_prev) begin
      lf_ready <= 1'b1;
    end
  end

  // ==========================================================
  // start-up delay completion per target
  always_comb begin
    start_done = 1'b0;
    case (target_sel.src)
      clock_switch_pkg::SRC_HF:  start_done = hf_ready;
      clock_switch_pkg::SRC_LF:  start_done = lf_ready && new_edges >= LF_EDGES &&
                                              (old_seen ||
                                               active_sel.src == clock_switch_pkg::SRC_NONE);
      clock_switch_pkg::SRC_SEC: start_done = new_edges >= EXT_EDGES;
      clock_switch_pkg::SRC_EXT: start_done = new_edges >= EXT_EDGES;
      default:                   start_done = 1'b0;
    endcase
  end

  // ==========================================================
  // handover sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_IDLE;
      active_sel <= clock_switch_pkg::SEL_NONE;
      target_sel <= clock_switch_pkg::SEL_NONE;
      new_edges  <= 2'h0;
      old_seen   <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          new_edges <= 2'h0;
          old_seen  <= 1'b0;
          // cfg reads zero until the synchroniser fills; no switch on that
          if (pins_valid && wanted_sel != active_sel) begin
            target_sel <= wanted_sel;
            state      <= ST_START;
          end
        end
        ST_START: begin
          if (new_rise && new_edges != 2'h3) begin
            new_edges <= new_edges + 2'h1;
          end
          if (cur_rise) begin
            old_seen <= 1'b1;
          end
          if (start_done) begin
            new_edges <= 2'h0;
            state     <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          if (new_rise) begin
            new_edges <= new_edges + 2'h1;
            if (new_edges + 2'h1 == SYNC_EDGES) begin
              state <= ST_WAIT_FALL;
            end
          end
        end
        ST_WAIT_FALL: begin
          // nothing to wait for when no clock was running yet
          if (cur_fall || active_sel.src == clock_switch_pkg::SRC_NONE) begin
            state <= ST_HOLD_LOW;
          end
        end
        ST_HOLD_LOW: begin
          if (new_rise) begin
            active_sel <= target_sel;
            state      <= ST_UPDATE;
          end
        end
        ST_UPDATE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // system clock output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clk <= 1'b0;
    end else begin
      case (state)
        ST_WAIT_FALL: sys_clk <= cur_fall ? 1'b0 : cur_lvl;
        ST_HOLD_LOW:  sys_clk <= new_rise;
        default:      sys_clk <= cur_lvl;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_busy <= 1'b0;
    end else begin
      switch_busy <= (state != ST_IDLE) || (wanted_sel != active_sel);
    end
  end

  // ==========================================================
  // stable flag, only moved once the new clock is in charge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hf_osc_stable_flag <= 1'b0;
    end else if (!hf_ready) begin
      hf_osc_stable_flag <= 1'b0;
    end else if (state == ST_UPDATE) begin
      hf_osc_stable_flag <= (active_sel.src == clock_switch_pkg::SRC_HF);
    end
  end

  // ==========================================================
  // apb slave: no wait states, answer registered at setup
  logic       setup_phase;
  logic       access_done;
  logic [9:0] word_idx;

  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign word_idx    = paddr[11:2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_phase;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (setup_phase) begin
        if (word_idx == clock_switch_pkg::CTRL_OFFSET[11:2]) begin
          prdata[clock_switch_pkg::FREQ_LSB +: 4] <= int_osc_freq_select;
          prdata[clock_switch_pkg::SRC_LSB +: 2]  <= sys_clock_source_select;
        end else if (word_idx == clock_switch_pkg::STATUS_OFFSET[11:2]) begin
          prdata[clock_switch_pkg::STAT_HF_READY]    <= hf_ready;
          prdata[clock_switch_pkg::STAT_LF_READY]    <= lf_ready;
          prdata[clock_switch_pkg::STAT_HF_STABLE]   <= hf_osc_stable_flag;
          prdata[clock_switch_pkg::STAT_SWITCH_BUSY] <= switch_busy;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // control register: writes take effect at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_osc_freq_select     <= clock_switch_pkg::FREQ_RESET;
      sys_clock_source_select <= clock_switch_pkg::SRC_RESET;
    end else if (access_done && pwrite &&
                 word_idx == clock_switch_pkg::CTRL_OFFSET[11:2]) begin
      int_osc_freq_select     <= pwdata[clock_switch_pkg::FREQ_LSB +: 4];
      sys_clock_source_select <= pwdata[clock_switch_pkg::SRC_LSB +: 2];
    end
  end

endmodule

`default_nettype wire

// [dv/clock_switch_chk.sv]
`default_nettype none

module clock_switch_chk (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // requests and clock outputs
  input wire logic        watchdog_enable,
  input wire logic        periph_lf_request,
  input wire logic        hf_osc_enable,
  input wire logic        lf_osc_enable,
  input wire logic        sys_clk,
  input wire logic        switch_busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // helpers
  // saturates well above the start-up count
  logic [8:0] hf_on_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hf_on_cnt <= 9'h000;
    else if (!hf_osc_enable) hf_on_cnt <= 9'h000;
    else if (hf_on_cnt != 9'h1ff) hf_on_cnt <= hf_on_cnt + 9'h001;
  end

  // ==========================================================
  // properties
  property p_ready_after_setup; psel && !penable |=> pready; endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("ready missing");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_err_unmapped; psel && !penable && paddr[11:3] != 9'h000 |=> pslverr; endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
  property p_err_mapped; psel && !penable && paddr[11:3] == 9'h000 |=> !pslverr; endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");
  property p_hf_startup;
    $fell(switch_busy) && hf_osc_enable |-> hf_on_cnt >= clock_switch_pkg::HF_STARTUP_CYCLES;
  endproperty
  a_hf_startup: assert property (p_hf_startup) else $error("hf used before start-up");
  property p_lf_kept; (watchdog_enable || periph_lf_request)[*4] |=> lf_osc_enable; endproperty
  a_lf_kept: assert property (p_lf_kept) else $error("lf stopped while requested");
  property p_lf_stop;
    $fell(switch_busy) && hf_osc_enable && !watchdog_enable && !periph_lf_request
      && !$past(watchdog_enable, 4) && !$past(periph_lf_request, 4) |-> ##[0:8] !lf_osc_enable;
  endproperty
  a_lf_stop: assert property (p_lf_stop) else $error("lf left running on hf");
  property p_clk_high; $rose(sys_clk) |=> sys_clk; endproperty
  a_clk_high: assert property (p_clk_high) else $error("runt high pulse on sys_clk");
  property p_done_after_rise; $fell(switch_busy) |-> $past(sys_clk) || $past(sys_clk, 2); endproperty
  a_done_after_rise: assert property (p_done_after_rise) else $error("switch done early");
  property p_status_hf_off;
    psel && penable && pready && !pwrite && paddr[11:2] == 10'h001 && !hf_osc_enable
      && !$past(hf_osc_enable, 4) |-> !prdata[4] && !prdata[0];
  endproperty
  a_status_hf_off: assert property (p_status_hf_off) else $error("hf status while off");

  c_refused: cover property (pready && pslverr);
  c_done_hf: cover property ($fell(switch_busy) && hf_osc_enable);
  c_done_lf: cover property ($fell(switch_busy) && lf_osc_enable && !hf_osc_enable);
endmodule

bind system_clock_switch clock_switch_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .watchdog_enable(watchdog_enable), .periph_lf_request(periph_lf_request),
  .hf_osc_enable(hf_osc_enable), .lf_osc_enable(lf_osc_enable), .sys_clk(sys_clk),
  .switch_busy(switch_busy)
);

`default_nettype wire

// [dv/tb_top.sv]
`default_nettype none

`define CHK(nm, ex, got) \
  begin samples_checked++; if ((got) !== (ex)) begin errors++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // oscillator periods in pclk cycles, all slower than pclk/4
  localparam int HF_PER = 8;
  localparam int LF_PER = 40;
  localparam int SEC_PER = 12;
  localparam int EXT_PER = 18;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic        hf_osc = 1'b0, lf_osc = 1'b0, sec_osc = 1'b0, ext_osc = 1'b0;
  logic [1:0]  cfg_clock_select = 2'h0;
  logic        watchdog_enable = 1'b0;
  logic        periph_lf_request = 1'b0;
  logic        hf_osc_enable, lf_osc_enable, sys_clk, switch_busy;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  system_clock_switch DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hf_internal_osc(hf_osc), .lf_internal_osc(lf_osc), .secondary_osc(sec_osc),
    .ext_clock_in(ext_osc), .cfg_clock_select(cfg_clock_select),
    .watchdog_enable(watchdog_enable), .periph_lf_request(periph_lf_request),
    .hf_osc_enable(hf_osc_enable), .lf_osc_enable(lf_osc_enable), .sys_clk(sys_clk),
    .switch_busy(switch_busy)
  );

  // ==========================================================
  // clocks and oscillators
  initial begin
    forever #5 pclk = ~pclk;
  end
  // gated oscillators sit low while disabled; edges never meet pclk rises
  always #40 hf_osc = hf_osc_enable ? ~hf_osc : 1'b0;
  always #200 lf_osc = lf_osc_enable ? ~lf_osc : 1'b0;
  always #60 sec_osc = ~sec_osc;
  always #90 ext_osc = ~ext_osc;

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      test_done();
    end
  end

  // ==========================================================
  // tasks
  task automatic test_done();
    if (errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] ctrl(input logic [3:0] f, input logic [1:0] s);
    ctrl = ({28'h0, f} << clock_switch_pkg::FREQ_LSB) | ({30'h0, s} << clock_switch_pkg::SRC_LSB);
  endfunction

  function automatic logic [31:0] stat(input logic hr, input logic lr, input logic hs);
    stat = 32'h00000000;
    stat[clock_switch_pkg::STAT_HF_READY] = hr;
    stat[clock_switch_pkg::STAT_LF_READY] = lr;
    stat[clock_switch_pkg::STAT_HF_STABLE] = hs;
  endfunction

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] ex, input string nm);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h00000000, r, e);
    `CHK(nm, ex, r)
  endtask

  task automatic wait_idle(output int dur);
    int n;
    n = 0;
    dur = 0;
    while (switch_busy !== 1'b1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    while (switch_busy === 1'b1) begin
      @(posedge pclk);
      dur++;
    end
  endtask

  task automatic switch_to(input logic [31:0] d, output int dur);
    logic [31:0] r;
    logic        e;
    apb(1'b1, clock_switch_pkg::CTRL_OFFSET, d, r, e);
    wait_idle(dur);
  endtask

  task automatic wait_rise(inout int n);
    logic prev;
    prev = sys_clk;
    forever begin
      @(posedge pclk);
      n++;
      if ((prev === 1'b0 && sys_clk === 1'b1) || n > 3000) break;
      prev = sys_clk;
    end
  endtask

  task automatic chk_period(input int ex, input string nm);
    int n;
    n = 0;
    wait_rise(n);
    n = 0;
    wait_rise(n);
    `CHK(nm, ex, n)
  endtask

  // ==========================================================
  // scenarios
  task automatic t_boot();
    int d;
    wait_idle(d);
    rd_chk(clock_switch_pkg::CTRL_OFFSET, ctrl(4'h7, 2'h0), "ctrl reset");
    rd_chk(clock_switch_pkg::STATUS_OFFSET, stat(1'b1, 1'b0, 1'b1), "status boot");
    `CHK("hf enable", 1'b1, hf_osc_enable)
    chk_period(HF_PER * 32, "boot period");
  endtask

  task automatic t_refuse();
    logic [31:0] r;
    logic        e;
    apb(1'b1, 12'h008, 32'hffffffff, r, e);
    `CHK("write unmapped err", 1'b1, e)
    apb(1'b0, 12'hffc, 32'h00000000, r, e);
    `CHK("read unmapped err", 1'b1, e)
    apb(1'b1, clock_switch_pkg::STATUS_OFFSET, 32'hffffffff, r, e);
    `CHK("status write err", 1'b0, e)
    rd_chk(clock_switch_pkg::CTRL_OFFSET, ctrl(4'h7, 2'h0), "ctrl kept");
  endtask

  task automatic t_to_lf();
    int d;
    switch_to(ctrl(4'h0, 2'h2), d);
    rd_chk(clock_switch_pkg::STATUS_OFFSET, stat(1'b0, 1'b1, 1'b0), "status lf");
    `CHK("hf off on lf", 1'b0, hf_osc_enable)
    chk_period(LF_PER, "lf period");
  endtask

  task automatic t_to_hf(input logic wdt);
    int d;
    watchdog_enable <= wdt;
    switch_to(ctrl(4'hf, 2'h2), d);
    `CHK("hf start delay", 1'b1, d >= clock_switch_pkg::HF_STARTUP_CYCLES)
    repeat (8) @(posedge pclk);
    `CHK("lf after hf", wdt, lf_osc_enable)
    rd_chk(clock_switch_pkg::STATUS_OFFSET, stat(1'b1, wdt, 1'b1), "status hf");
    chk_period(HF_PER, "hf period");
  endtask

  task automatic t_same_osc();
    int d;
    for (int i = 0; i < 4; i++) begin
      switch_to(ctrl(4'hc + i[3:0], 2'h2), d);
      `CHK("same osc fast", 1'b1, d < clock_switch_pkg::HF_STARTUP_CYCLES)
      chk_period(HF_PER << (3 - i), "postscaled period");
    end
  endtask

  task automatic t_periph();
    periph_lf_request <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK("lf for peripheral", 1'b1, lf_osc_enable)
    periph_lf_request <= 1'b0;
  endtask

  task automatic t_sources();
    int d;
    switch_to(ctrl(4'hf, 2'h1), d);
    chk_period(SEC_PER, "secondary period");
    `CHK("hf off on secondary", 1'b0, hf_osc_enable)
    cfg_clock_select <= 2'h1;
    switch_to(ctrl(4'hf, 2'h0), d);
    chk_period(EXT_PER, "external period");
    switch_to(ctrl(4'he, 2'h3), d);
    chk_period(HF_PER * 2, "upper select period");
  endtask

  task automatic t_rereset();
    int d;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK("hf off after reset", 1'b0, hf_osc_enable)
    wait_idle(d);
    rd_chk(clock_switch_pkg::CTRL_OFFSET, ctrl(4'h7, 2'h0), "ctrl after reset");
    chk_period(EXT_PER, "config source again");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_boot();
    t_refuse();
    t_to_lf();
    t_to_hf(1'b0);
    t_to_lf();
    t_to_hf(1'b1);
    watchdog_enable <= 1'b0;
    t_same_osc();
    t_periph();
    t_sources();
    t_rereset();
    test_done();
  end
endmodule

`default_nettype wire
